//--- hw/bm_fifo_pkg.sv
`default_nettype none
package bm_fifo_pkg;
    localparam int DATA_W = 36;
    localparam int P18_W = 18;
    localparam int P9_W = 9;
    localparam int BYTE_W = 8;
    localparam int FALL_THROUGH_MODE_EDGES = 3;
    localparam int NONINT_TOP = 32;
    // last piece index for split words
    localparam logic [1:0] LAST18 = 2'h1;
    localparam logic [1:0] LAST9 = 2'h3;
    // parity positions for interspersed offset loads
    localparam int PAR0 = 8;
    localparam int PAR1 = 17;
    localparam int PAR2 = 26;
    localparam int PAR3 = 35;
    // fields of the sampled configuration vector
    localparam int CF_TIMING = 0;
    localparam int CF_RT_LAT = 1;
    localparam int CF_ORDER = 5;
    localparam int CF_PARITY = 6;
    localparam int CF_SEL0 = 7;
    localparam int CF_FALL_THROUGH_MODE = 10;
    localparam int CF_MODE = 2;
    localparam int CF_MODE_W = 3;
    localparam int OFS_SEL_W = 3;
    localparam int CFG_W = 11;
    // positions in the synchronised pin vector
    localparam int PN_DATA = 0;
    localparam int PN_MRS = 36;
    localparam int PN_LD = 37;
    localparam int PN_RT = 38;
    localparam int PN_REN = 39;
    localparam int PN_WEN = 40;
    localparam int PN_RCLK = 41;
    localparam int PN_WCLK = 42;
    localparam int PN_CFG = 43;
    localparam int PIN_W = 54;
    // default almost-empty and almost-full offsets
    localparam logic [15:0] DEF_OFS [8] = '{16'h0007, 16'h000f, 16'h001f, 16'h003f,
                                            16'h007f, 16'h00ff, 16'h01ff, 16'h03ff};
    // port widths, coded as {match, write width, read width}
    typedef enum logic [2:0] {
        WM_36_36 = 3'h0,
        WM_36_18 = 3'h4,
        WM_36_9 = 3'h5,
        WM_18_36 = 3'h6,
        WM_9_36 = 3'h7
    } width_mode_e;
    // position of a piece inside a long word
    function automatic logic [1:0] piece_pos(input logic [1:0] idx, input logic [1:0] last,
                                             input logic little);
        return little ? idx : 2'(last - idx);
    endfunction
endpackage
`default_nettype wire

//--- hw/fifo_mem_if.sv
`default_nettype none
interface fifo_mem_if #(parameter int ADDR_W = 10, parameter int DATA_W = 36);
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;
    modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
    modport store (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface
`default_nettype wire

//--- hw/fifo_word_mem.sv
`default_nettype none
module fifo_word_mem #(
    parameter int ADDR_W = 10, // address width
    parameter int DATA_W = 36 // word width
) (
    input wire logic sys_clk_i, // system clock
    input wire logic reset_n_i, // async reset, active low
    input wire logic clk_en_i, // freezes state when low
    fifo_mem_if.store mem // port from the control logic
);
    logic [DATA_W-1:0] cells_q [1<<ADDR_W];
    logic [DATA_W-1:0] rd_data_q;

    // storage array, not reset
    always_ff @(posedge sys_clk_i) begin
        if (clk_en_i && mem.wr_en) begin
            cells_q[mem.wr_addr] <= mem.wr_data;
        end
    end

    // registered read port
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_q <= '0;
        end else if (clk_en_i && mem.rd_en) begin
            rd_data_q <= cells_q[mem.rd_addr];
        end
    end

    assign mem.rd_data = rd_data_q;
endmodule // fifo_word_mem
`default_nettype wire

//--- hw/bm_fifo_ctrl.sv
`default_nettype none
module bm_fifo_ctrl #(
    parameter int ADDR_W = 10 // log2 of queue depth in words
) (
    input wire logic sys_clk_i, // system clock
    input wire logic reset_n_i, // async reset, active low
    input wire logic clk_en_i, // freezes all state when low
    input wire logic master_reset_n_i, // master reset pin
    input wire logic write_clk_i, // write clock pin
    input wire logic read_clk_i, // read clock pin
    input wire logic write_enable_n_i, // write enable pin
    input wire logic read_enable_n_i, // read enable pin
    input wire logic retransmit_request_n_i, // retransmit pin
    input wire logic offset_load_n_i, // offset load pin
    input wire logic [bm_fifo_pkg::DATA_W-1:0] write_data_in_i, // write data pins
    input wire logic flag_timing_select_i, // flag timing strap
    input wire logic retransmit_latency_select_i, // retransmit latency strap
    input wire logic width_matching_select_i, // width matching strap
    input wire logic write_width_select_i, // write width strap
    input wire logic read_width_select_i, // read width strap
    input wire logic byte_order_select_i, // byte order strap
    input wire logic parity_placement_select_i, // parity placement strap
    input wire logic default_offset_sel_0_i, // default offset strap 0
    input wire logic default_offset_sel_1_i, // default offset strap 1
    input wire logic fallthrough_or_serial_in_i, // mode strap, serial in later
    output logic [bm_fifo_pkg::DATA_W-1:0] read_data_o, // read data
    output logic empty_or_out_ready_o, // empty or output ready, active low
    output logic full_or_in_ready_o, // full or input ready, active low
    output logic almost_empty_flag_n_o, // almost-empty flag
    output logic almost_full_flag_n_o, // almost-full flag
    output logic fall_through_mode_o // captured fall-through mode
);
    import bm_fifo_pkg::*;
    localparam int OFS_W = ADDR_W + 1;
    localparam logic [OFS_W-1:0] DEPTH_C = OFS_W'(1) << ADDR_W;
    localparam logic [1:0] FT_LAST = 2'(FALL_THROUGH_MODE_EDGES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a change counts once stages two and three agree
    logic [PIN_W-1:0] s1_q, s2_q, s3_q, pin_q;
    wire [PIN_W-1:0] pins_w = {fallthrough_or_serial_in_i, offset_load_n_i, default_offset_sel_1_i,
                               default_offset_sel_0_i, parity_placement_select_i, byte_order_select_i,
                               width_matching_select_i, write_width_select_i, read_width_select_i,
                               retransmit_latency_select_i, flag_timing_select_i, write_clk_i, read_clk_i,
                               write_enable_n_i, read_enable_n_i, retransmit_request_n_i, offset_load_n_i,
                               master_reset_n_i, write_data_in_i};
    wire [PIN_W-1:0] pin_d = (s2_q & s3_q) | (pin_q & (s2_q | s3_q));

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            pin_q <= '0;
        end else if (clk_en_i) begin
            s1_q <= pins_w;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= pin_d;
        end
    end

    // pin events and levels
    wire wr_edge_w = pin_d[PN_WCLK] & ~pin_q[PN_WCLK];
    wire rd_edge_w = pin_d[PN_RCLK] & ~pin_q[PN_RCLK];
    wire mrs_n_w = pin_q[PN_MRS];
    wire run_w = clk_en_i & mrs_n_w;
    wire wen_w = ~pin_d[PN_WEN];
    wire ren_w = ~pin_d[PN_REN];
    wire rt_w = ~pin_d[PN_RT];
    wire ld_w = ~pin_d[PN_LD];
    wire [DATA_W-1:0] din_w = pin_d[PN_DATA +: DATA_W];
    wire [CFG_W-1:0] cfg_pin_w = pin_q[PN_CFG +: CFG_W];

    ////////////////////////////////////////////////////////////////////////////
    // configuration captured while master reset is held
    logic [CFG_W-1:0] cfg_q;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_q <= '0;
        end else if (clk_en_i && !mrs_n_w) begin
            cfg_q <= cfg_pin_w;
        end
    end

    // configuration decode
    wire sync_flags_w = cfg_q[CF_TIMING];
    wire zero_lat_w = ~cfg_q[CF_RT_LAT];
    wire little_w = cfg_q[CF_ORDER];
    wire fall_through_mode_w = cfg_q[CF_FALL_THROUGH_MODE];
    wire interspersed_w = cfg_q[CF_PARITY];
    wire [CF_MODE_W-1:0] mode_raw_w = cfg_q[CF_MODE +: CF_MODE_W];
    wire width_mode_e mode_w = mode_raw_w[CF_MODE_W-1] ? width_mode_e'(mode_raw_w) : WM_36_36;
    wire [1:0] wr_last_w = (mode_w == WM_18_36) ? LAST18 : (mode_w == WM_9_36) ? LAST9 : '0;
    wire [1:0] rd_last_w = (mode_w == WM_36_18) ? LAST18 : (mode_w == WM_36_9) ? LAST9 : '0;
    wire wr_is9_w = mode_w == WM_9_36;
    wire rd_is9_w = mode_w == WM_36_9;
    wire [OFS_W-1:0] def_ofs_w = OFS_W'(DEF_OFS[cfg_pin_w[CF_SEL0 +: OFS_SEL_W]]);

    // drop one narrow piece into a long word
    function automatic logic [DATA_W-1:0] place(input logic [DATA_W-1:0] w, input logic [DATA_W-1:0] p,
                                                input logic [1:0] pos, input logic is9);
        logic [DATA_W-1:0] r;
        r = w;
        if (is9) begin
            r[pos*P9_W +: P9_W] = p[P9_W-1:0];
        end else begin
            r[pos*P18_W +: P18_W] = p[P18_W-1:0];
        end
        return r;
    endfunction

    // take one narrow piece out of a long word
    function automatic logic [DATA_W-1:0] pick(input logic [DATA_W-1:0] w, input logic [1:0] pos,
                                               input logic is9);
        return is9 ? DATA_W'(w[pos*P9_W +: P9_W]) : DATA_W'(w[pos*P18_W +: P18_W]);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // write side: piece assembly, queue writes and parallel offset loads
    logic [DATA_W-1:0] asm_q;
    logic [1:0] wr_idx_q;
    logic [ADDR_W-1:0] wr_ptr_q, rd_ptr_q;
    logic [OFS_W-1:0] count_q, empty_ofs_q, full_ofs_q;
    logic ofs_sel_q;
    wire full_w = count_q == DEPTH_C;
    wire wr_go_w = run_w & wr_edge_w & wen_w & ~ld_w & ~full_w;
    wire ofs_go_w = run_w & wr_edge_w & wen_w & ld_w;
    wire [1:0] wr_pos_w = piece_pos(wr_idx_q, wr_last_w, little_w);
    wire [DATA_W-1:0] asm_d = (wr_last_w == '0) ? din_w : place(asm_q, din_w, wr_pos_w, wr_is9_w);
    wire wr_done_w = wr_go_w & (wr_idx_q == wr_last_w);
    wire [ADDR_W-1:0] wr_ptr_d = wr_done_w ? ADDR_W'(wr_ptr_q + 1'b1) : wr_ptr_q;
    wire [OFS_W-1:0] ofs_in_w = interspersed_w ?
        OFS_W'({din_w[PAR3-1 -: BYTE_W], din_w[PAR2-1 -: BYTE_W], din_w[PAR1-1 -: BYTE_W], din_w[PAR0-1:0]})
        : OFS_W'(din_w[NONINT_TOP-1:0]);

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            asm_q <= '0;
            wr_idx_q <= '0;
            wr_ptr_q <= '0;
            ofs_sel_q <= 1'b0;
            empty_ofs_q <= '0;
            full_ofs_q <= '0;
        end else if (clk_en_i) begin
            if (!mrs_n_w) begin
                asm_q <= '0;
                wr_idx_q <= '0;
                wr_ptr_q <= '0;
                ofs_sel_q <= 1'b0;
                empty_ofs_q <= def_ofs_w;
                full_ofs_q <= def_ofs_w;
            end else begin
                wr_ptr_q <= wr_ptr_d;
                if (wr_go_w) begin
                    asm_q <= asm_d;
                    wr_idx_q <= wr_done_w ? '0 : 2'(wr_idx_q + 1'b1);
                end
                if (ofs_go_w) begin
                    ofs_sel_q <= ~ofs_sel_q;
                    if (ofs_sel_q) begin
                        full_ofs_q <= ofs_in_w;
                    end else begin
                        empty_ofs_q <= ofs_in_w;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read side: fetches, piece walk, retransmit and fall-through fill
    logic [DATA_W-1:0] word_q;
    logic [1:0] rd_idx_q, ft_cnt_q;
    logic out_valid_q, fetch_q;
    wire have_w = count_q != '0;
    wire rt_go_w = run_w & rd_edge_w & rt_w;
    wire more_w = out_valid_q & (rd_idx_q != rd_last_w);
    wire empty_w = ~have_w & ~more_w;
    wire consume_w = run_w & rd_edge_w & ~rt_w & ren_w & (out_valid_q | ~fall_through_mode_w);
    wire ft_go_w = run_w & rd_edge_w & ~rt_w & fall_through_mode_w & ~out_valid_q & ~fetch_q & have_w &
                   (ft_cnt_q == FT_LAST);
    wire rt_zero_w = rt_go_w & zero_lat_w & (wr_ptr_q != '0);
    wire fetch_go_w = rt_zero_w | (consume_w & ~more_w & have_w) | ft_go_w;
    wire [ADDR_W-1:0] fetch_addr_w = rt_go_w ? '0 : rd_ptr_q;
    wire [ADDR_W-1:0] rd_ptr_d = fetch_go_w ? ADDR_W'(fetch_addr_w + 1'b1) : rt_go_w ? '0 : rd_ptr_q;
    wire [OFS_W-1:0] count_d = rt_go_w ? OFS_W'({1'b0, wr_ptr_d} - fetch_go_w)
                                       : OFS_W'(count_q + wr_done_w - fetch_go_w);
    wire [1:0] rd_pos_w = piece_pos(rd_idx_q, rd_last_w, little_w);

    fifo_mem_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mem_bus ();
    assign mem_bus.wr_en = wr_done_w;
    assign mem_bus.wr_addr = wr_ptr_q;
    assign mem_bus.wr_data = asm_d;
    assign mem_bus.rd_en = fetch_go_w;
    assign mem_bus.rd_addr = fetch_addr_w;

    fifo_word_mem #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mem (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .mem(mem_bus)
    );

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_ptr_q <= '0;
            count_q <= '0;
            fetch_q <= 1'b0;
            word_q <= '0;
            out_valid_q <= 1'b0;
            rd_idx_q <= '0;
            ft_cnt_q <= '0;
        end else if (clk_en_i) begin
            if (!mrs_n_w) begin
                rd_ptr_q <= '0;
                count_q <= '0;
                fetch_q <= 1'b0;
                word_q <= '0;
                out_valid_q <= 1'b0;
                rd_idx_q <= '0;
                ft_cnt_q <= '0;
            end else begin
                rd_ptr_q <= rd_ptr_d;
                count_q <= count_d;
                fetch_q <= fetch_go_w;
                if (fetch_q) begin
                    word_q <= mem_bus.rd_data;
                    out_valid_q <= 1'b1;
                    rd_idx_q <= '0;
                end else if (rt_go_w && fall_through_mode_w) begin
                    out_valid_q <= 1'b0;
                end else if (consume_w && more_w) begin
                    rd_idx_q <= 2'(rd_idx_q + 1'b1);
                end else if (consume_w && !fetch_go_w) begin
                    out_valid_q <= 1'b0;
                end
                if (fall_through_mode_w && !out_valid_q && have_w && !fetch_q) begin
                    if (rd_edge_w && !rt_w) begin
                        ft_cnt_q <= (ft_cnt_q == FT_LAST) ? '0 : 2'(ft_cnt_q + 1'b1);
                    end
                end else begin
                    ft_cnt_q <= '0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // programmable flags and status outputs
    logic ae_n_q, af_n_q, eor_q, ffir_q, fall_through_mode_q;
    logic [DATA_W-1:0] read_data_q;
    wire ae_cond_w = count_d < empty_ofs_q;
    wire af_cond_w = OFS_W'(DEPTH_C - count_d) <= full_ofs_q;
    wire ae_async_w = (rd_edge_w & ae_cond_w) ? 1'b0 : (wr_edge_w & ~ae_cond_w) ? 1'b1 : ae_n_q;
    wire af_async_w = (rd_edge_w & af_cond_w) ? 1'b0 : wr_edge_w ? ~af_cond_w : af_n_q;
    wire ae_n_d = sync_flags_w ? (rd_edge_w ? ~ae_cond_w : ae_n_q) : ae_async_w;
    wire af_n_d = sync_flags_w ? (wr_edge_w ? ~af_cond_w : af_n_q) : af_async_w;
    wire [DATA_W-1:0] piece_w = (rd_last_w == '0) ? word_q : pick(word_q, rd_pos_w, rd_is9_w);

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ae_n_q <= 1'b0;
            af_n_q <= 1'b1;
            read_data_q <= '0;
            eor_q <= 1'b0;
            ffir_q <= 1'b1;
            fall_through_mode_q <= 1'b0;
        end else if (clk_en_i) begin
            ae_n_q <= mrs_n_w ? ae_n_d : 1'b0;
            af_n_q <= mrs_n_w ? af_n_d : 1'b1;
            read_data_q <= piece_w;
            eor_q <= fall_through_mode_w ? ~out_valid_q : ~empty_w;
            ffir_q <= fall_through_mode_w ? full_w : ~full_w;
            fall_through_mode_q <= fall_through_mode_w;
        end
    end

    assign read_data_o = read_data_q;
    assign empty_or_out_ready_o = eor_q;
    assign full_or_in_ready_o = ffir_q;
    assign almost_empty_flag_n_o = ae_n_q;
    assign almost_full_flag_n_o = af_n_q;
    assign fall_through_mode_o = fall_through_mode_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    property p_ae_async_low;
        run_w && !sync_flags_w && rd_edge_w && ae_cond_w |=> !ae_n_q;
    endproperty
    a_ae_async_low: assert property (p_ae_async_low) else $error("almost-empty not low after read edge");
    property p_ae_async_high;
        run_w && !sync_flags_w && wr_edge_w && !rd_edge_w && !ae_cond_w |=> ae_n_q;
    endproperty
    a_ae_async_high: assert property (p_ae_async_high) else $error("almost-empty not high after write");
    property p_af_async_low;
        run_w && !sync_flags_w && rd_edge_w && af_cond_w |=> !af_n_q;
    endproperty
    a_af_async_low: assert property (p_af_async_low) else $error("almost-full not low after read edge");
    property p_ae_sync_hold;
        run_w && sync_flags_w && !rd_edge_w |=> $stable(ae_n_q);
    endproperty
    a_ae_sync_hold: assert property (p_ae_sync_hold) else $error("almost-empty moved without read edge");
    property p_af_sync_hold;
        run_w && sync_flags_w && !wr_edge_w |=> $stable(af_n_q);
    endproperty
    a_af_sync_hold: assert property (p_af_sync_hold) else $error("almost-full moved without write edge");
    property p_ae_level;
        run_w && sync_flags_w && rd_edge_w && !wr_edge_w |=> ae_n_q == (count_q >= empty_ofs_q);
    endproperty
    a_ae_level: assert property (p_ae_level) else $error("almost-empty level wrong");
    property p_af_level;
        run_w && sync_flags_w && wr_edge_w && !ld_w |=> af_n_q == (OFS_W'(DEPTH_C - count_q) > full_ofs_q);
    endproperty
    a_af_level: assert property (p_af_level) else $error("almost-full level wrong");
    property p_cfg_hold;
        mrs_n_w |=> $stable(cfg_q);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("configuration changed outside master reset");
    property p_rt_ptr;
        rt_go_w && !zero_lat_w |=> rd_ptr_q == '0;
    endproperty
    a_rt_ptr: assert property (p_rt_ptr) else $error("retransmit did not rewind read pointer");
    property p_rt_zero;
        rt_zero_w |=> fetch_q && rd_ptr_q == ADDR_W'(1);
    endproperty
    a_rt_zero: assert property (p_rt_zero) else $error("zero-latency retransmit did not fetch");

    c_rt_zero: cover property (rt_zero_w);
    c_ft_fill: cover property (ft_go_w);
    c_ofs_load: cover property (ofs_go_w);
    c_full: cover property (run_w && full_w);
endmodule // bm_fifo_ctrl
`default_nettype wire

//--- testbench/pin_side.sv
`default_nettype none
// writer and reader on the pin side; pin clocks move only inside frames
module pin_side (
    input wire logic clk_i, // system clock
    output logic wclk_o = 1'b0, // write clock
    output logic rclk_o = 1'b0, // read clock
    output logic wen_n_o = 1'b1, // write enable
    output logic ren_n_o = 1'b1, // read enable
    output logic rt_n_o = 1'b1, // retransmit
    output logic ld_n_o = 1'b1, // offset load
    output logic [35:0] d_o = 36'h0 // write data
);
    timeunit 1ns;
    timeprecision 1ps;
    // one pin clock pulse, each phase four system cycles
    task automatic pulse(input logic w);
        repeat (4) @(posedge clk_i);
        #2 {wclk_o, rclk_o} = {w, !w};
        repeat (4) @(posedge clk_i);
        #2 {wclk_o, rclk_o} = 2'h0;
        repeat (4) @(posedge clk_i);
    endtask
    // write one unit; load low steers it to the offsets
    task automatic wr(input logic [35:0] d, input logic ld);
        @(posedge clk_i);
        #2 {d_o, wen_n_o, ld_n_o} = {d, 1'b0, ld};
        pulse(1'b1);
        #2 {d_o, wen_n_o, ld_n_o} = {~d, 2'h3}; // released data is not held
    endtask
    // one read edge with chosen enable and retransmit levels
    task automatic rd(input logic en, input logic rt);
        @(posedge clk_i);
        #2 {ren_n_o, rt_n_o} = {en, rt};
        pulse(1'b0);
        #2 {ren_n_o, rt_n_o} = 2'h3;
    endtask
endmodule // pin_side
`default_nettype wire

//--- testbench/tb_bus_matching_fifo_flags_retransmit.sv
`default_nettype none
module tb_bus_matching_fifo_flags_retransmit;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AW = 4;
    localparam int DP = 1 << AW;
    logic clk = 1'b0, rst_n = 1'b0, mrs_n = 1'b0, ft = 1'b0;
    logic [10:0] c = 11'h0;
    logic wc, rc, we_n, re_n, rt_n, ld_n, e_n, f_n, ae_n, af_n, fm, aex, afx;
    logic [35:0] d, q, v, w [4];
    logic [35:0] m [$];
    int errors = 0, n_tests = 0, n, ofs, wd, np;
    initial forever #25 clk = ~clk;
    pin_side pin_side_i (.clk_i(clk), .wclk_o(wc), .rclk_o(rc), .wen_n_o(we_n), .ren_n_o(re_n), .rt_n_o(rt_n),
        .ld_n_o(ld_n), .d_o(d));
    bm_fifo_ctrl #(.ADDR_W(AW)) bm_fifo_ctrl_i (.sys_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(1'b1),
        .master_reset_n_i(mrs_n), .write_clk_i(wc), .read_clk_i(rc), .write_enable_n_i(we_n),
        .read_enable_n_i(re_n), .retransmit_request_n_i(rt_n), .offset_load_n_i(ld_n), .write_data_in_i(d),
        .flag_timing_select_i(c[0]), .retransmit_latency_select_i(c[1]), .width_matching_select_i(c[4]),
        .write_width_select_i(c[3]), .read_width_select_i(c[2]), .byte_order_select_i(c[5]),
        .parity_placement_select_i(c[6]), .default_offset_sel_0_i(c[7]), .default_offset_sel_1_i(c[8]),
        .fallthrough_or_serial_in_i(ft), .read_data_o(q), .empty_or_out_ready_o(e_n), .full_or_in_ready_o(f_n),
        .almost_empty_flag_n_o(ae_n), .almost_full_flag_n_o(af_n), .fall_through_mode_o(fm));
    task automatic chk_d(input logic [35:0] g, input logic [35:0] x);
        n_tests++;
        if (g !== x) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic chk_f(input logic [3:0] g, input logic [3:0] x);
        chk_d({32'h0, g}, {32'h0, x});
    endtask
    task automatic results();
        $display("errors %0d of %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // expected status flags in standard mode
    function automatic logic [3:0] fx();
        return {n != 0, n < DP, aex, afx};
    endfunction
    // piece i of a long word in the selected byte order
    function automatic logic [35:0] pc(input logic [35:0] x, input int i, input int k, input int b);
        return (x >> ((c[5] ? i : k - 1 - i) * b)) & ((36'h1 << b) - 1);
    endfunction
    // master reset with straps held; mode pin is free afterwards
    task automatic mreset(input logic [10:0] s);
        @(posedge clk);
        #2 {c, ft, mrs_n, pin_side_i.ld_n_o} = {s, s[10], 1'b0, s[9]};
        repeat (6) @(posedge clk);
        #2 mrs_n = 1'b1;
        repeat (8) @(posedge clk);
        #2 {ft, pin_side_i.ld_n_o} = {~s[10], 1'b1};
        n = 0;
        ofs = s[7] ? 15 : 7;
        {aex, afx} = 2'h1;
        m.delete();
        repeat (4) @(posedge clk);
        chk_f({e_n, fm, ae_n, af_n}, {s[10], s[10], 2'h1});
    endtask
    // write one unit and track count and flags
    task automatic put(input logic [35:0] x);
        pin_side_i.wr(x, 1'b1);
        if (n < DP) begin
            m.push_back(x);
            n++;
        end
        afx = DP - n > ofs;
        if (!c[0]) aex = n >= ofs;
        chk_f({e_n, f_n, ae_n, af_n}, fx());
    endtask
    task automatic get();
        pin_side_i.rd(1'b0, 1'b1);
        chk_d(q, m.pop_front());
        n--;
        aex = n >= ofs;
        chk_f({e_n, f_n, ae_n, af_n}, fx());
    endtask
    initial begin
        void'($urandom(32));
        repeat (20) @(posedge clk);
        chk_d(q, 36'h0);
        chk_f({e_n, f_n, ae_n, af_n}, 4'h5);
        #2 rst_n = 1'b1;
        // fill past full, then drain, in both flag timings
        for (int t = 0; t < 2; t++) begin
            mreset({3'h0, 1'($urandom), 1'($urandom), 4'h0, 1'b1, 1'(t)});
            repeat (DP + 1) put(36'({$urandom, $urandom}));
            repeat (DP) get();
        end
        // retransmit after two reads, zero and normal latency
        for (int l = 0; l < 2; l++) begin
            mreset({9'h0, 1'(l), 1'b0});
            foreach (w[i]) begin
                w[i] = 36'({$urandom, $urandom});
                pin_side_i.wr(w[i], 1'b1);
            end
            for (int i = 0; i < 4; i++) begin
                if (i == 2) pin_side_i.rd(1'b1, 1'b0);
                if (i == 2 && l == 0) chk_d(q, w[0]);
                pin_side_i.rd(1'b0, 1'b1);
                chk_d(q, w[i < 2 ? i : i - 1 - l]);
            end
        end
        // narrow ports in both byte orders, unused pins random
        for (int k = 0; k < 8; k++) begin
            mreset({5'h0, k[0], 1'b1, k[2:1], 2'h2});
            wd = k[1] ? 9 : 18;
            np = 36 / wd;
            v = 36'({$urandom, $urandom});
            if (k[2]) begin
                for (int i = 0; i < np; i++) pin_side_i.wr(pc(v, i, np, wd) | (36'($urandom) << wd), 1'b1);
                pin_side_i.rd(1'b0, 1'b1);
                chk_d(q, v);
            end else begin
                pin_side_i.wr(v, 1'b1);
                for (int i = 0; i < np; i++) begin
                    pin_side_i.rd(1'b0, 1'b1);
                    chk_d(q, pc(v, i, np, wd));
                end
            end
        end
        // fall-through with offsets of three loaded over the data pins
        for (int p = 0; p < 2; p++) begin
            mreset({4'h8, 1'(p), 6'h2});
            repeat (2) pin_side_i.wr(p ? 36'h8_0402_0103 : 36'hf_0000_0003, 1'b0);
            for (int i = 0; i < 3; i++) begin
                w[i] = 36'({$urandom, $urandom});
                pin_side_i.wr(w[i], 1'b1);
                chk_f({1'b0, ae_n, af_n, f_n}, {1'b0, i == 2, 2'h2});
            end
            for (int i = 0; i < 3; i++) begin
                chk_f({3'h0, e_n}, 4'h1);
                pin_side_i.rd(1'b1, 1'b1);
            end
            chk_f({3'h0, e_n}, 4'h0);
            chk_d(q, w[0]);
        end
        results();
    end
    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        results();
    end
endmodule // tb_bus_matching_fifo_flags_retransmit
`default_nettype wire
